// ==== pkg/dnet_node_pkg.sv ====
package dnet_node_pkg;

   // ---------------------------------------------------------------
   // switch field layout
   // ---------------------------------------------------------------
   localparam int SW_W = 8;
   localparam int NODE_W = 6;
   localparam int NODE_LSB = 0;
   localparam int RATE_LSB = 6;
   localparam int RATE_W = 2;

   // bit-rate codes, as {switch 8, switch 7}
   localparam logic [1:0] RATE_125K = 2'h0;
   localparam logic [1:0] RATE_250K = 2'h1;
   localparam logic [1:0] RATE_500K = 2'h2;
   localparam logic [1:0] RATE_BAD = 2'h3;

   // ---------------------------------------------------------------
   // assembly addresses (class, instance, attribute)
   // ---------------------------------------------------------------
   localparam logic [7:0] ASM_CLASS = 8'h04;
   localparam logic [7:0] ASM_ATTR = 8'h03;
   localparam logic [7:0] IN1_INST = 8'h01;
   localparam logic [7:0] IN2_INST = 8'h02;
   localparam logic [7:0] OUT_INST = 8'h15;
   localparam logic [7:0] SENSOR_MASK = 8'h0f;
   localparam logic [7:0] VALVE_MASK = 8'h07;
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] REG_LAYOUT = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_VALVES = 8'h08;
   localparam logic [7:0] REG_INPUTS = 8'h0c;
   localparam int LAY_IN_LSB = 0;
   localparam int LAY_OUT_LSB = 8;
   localparam int ST_NODE_LSB = 0;
   localparam int ST_RATE_LSB = 8;
   localparam int ST_BAD_BIT = 12;
   localparam int ST_ONLINE_BIT = 13;

   // cycles the switch synchroniser needs before sampling
   localparam logic [1:0] SETTLE_CYCLES = 2'h3;

   typedef enum logic [2:0]
   {
      ST_SAMPLE = 3'b001,
      ST_RUN = 3'b010,
      ST_HALT = 3'b100
   } node_state_t;

endpackage

// ==== src/dnet_node_io.sv ====
`timescale 1ns/100ps

// What this block does
// (RL1) node id from switches 1-6, switch 1 lsb
// (RL2) switch off reads zero, on reads one
// (RL3) switches 7-8 pick 125, 250, 500 kbaud
// (RL4) both rate switches on: stay silent
// (RL5) switches sampled only at restart
// (RL6) power-up or reset message restarts node
// (RL7) two input layouts, one output layout
// (RL8) layouts chosen by parameter or connection setup
// (RL9) layout one: sensors 1-4 in bits 0-3
// (RL10) layout two: same byte plus second byte
// (RL11) output layout bits 0-2 drive valves 1-3
// (RL12) active or energised encodes as one
// (RL13) produced layout sent on each cyclic tick
// (RL14) explicit reads return the layout contents
// (RL15) unused input bits zero, unused output ignored
module dnet_node_io
   import dnet_node_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst_n, // sync reset, power-up restart
   input wire logic [SW_W-1:0] dip_sw, // config switches, bit0 = switch 1, on = 1
   input wire logic position_sensor_1, // sensor pin
   input wire logic position_sensor_2, // sensor pin
   input wire logic position_sensor_3, // sensor pin
   input wire logic position_sensor_4, // sensor pin
   input wire logic reset_msg, // restart request from stack, pulse
   input wire logic conn_setup, // i/o connection setup, pulse
   input wire logic [7:0] conn_prod_inst, // produced path instance
   input wire logic [7:0] conn_cons_inst, // consumed path instance
   input wire logic produce_tick, // cyclic produce request, pulse
   input wire logic rx_valid, // consumed output data, pulse
   input wire logic [7:0] rx_byte, // consumed output byte 0
   input wire logic expl_req, // explicit read request, pulse
   input wire logic [7:0] expl_class, // requested class
   input wire logic [7:0] expl_inst, // requested instance
   input wire logic [7:0] expl_attr, // requested attribute
   input wire logic [ADDR_W-1:0] reg_addr, // register byte address
   input wire logic [DATA_W-1:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
   output logic [NODE_W-1:0] node_id, // latched node identifier
   output logic [RATE_W-1:0] bit_rate_code, // latched rate code
   output logic rate_invalid, // prohibited rate latched
   output logic online, // node may use the bus
   output logic valve_drive_1, // solenoid valve 1
   output logic valve_drive_2, // solenoid valve 2
   output logic valve_drive_3, // solenoid valve 3
   output logic tx_valid, // produced frame, pulse
   output logic [1:0] tx_len, // produced byte count
   output logic [7:0] tx_byte0, // produced byte 0
   output logic [7:0] tx_byte1, // produced byte 1
   output logic conn_accept, // setup taken, pulse
   output logic conn_reject, // setup refused, pulse
   output logic expl_ack, // explicit answer, pulse
   output logic expl_ok, // address was valid
   output logic [1:0] expl_len, // answer byte count
   output logic [7:0] expl_byte0, // answer byte 0
   output logic [7:0] expl_byte1 // answer byte 1
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // {ok, len, byte0, byte1} for one assembly instance
   function automatic logic [18:0] read_layout(input logic [7:0] inst,
                                               input logic [3:0] sens,
                                               input logic [2:0] vlv);
      logic [7:0] sbyte;
      logic [7:0] vbyte;
      sbyte = {4'h0, sens} & SENSOR_MASK; // [RL9] [RL12] [RL15]
      vbyte = {5'h00, vlv} & VALVE_MASK;
      if (inst == IN1_INST)
      begin
         read_layout = {1'b1, LEN_ONE, sbyte, 8'h00}; // [RL9]
      end
      else if (inst == IN2_INST)
      begin
         read_layout = {1'b1, LEN_TWO, sbyte, 8'h00}; // [RL10]
      end
      else if (inst == OUT_INST)
      begin
         read_layout = {1'b1, LEN_ONE, vbyte, 8'h00}; // [RL11]
      end
      else
      begin
         read_layout = {1'b0, 2'h0, 8'h00, 8'h00};
      end
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [SW_W-1:0] dip_meta;
   logic [SW_W-1:0] dip_sync;
   logic [3:0] sensor_meta;
   logic [3:0] sensor_sync;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         dip_meta <= '0;
         dip_sync <= '0;
         sensor_meta <= '0;
         sensor_sync <= '0;
      end
      else
      begin
         dip_meta <= dip_sw;
         dip_sync <= dip_meta;
         sensor_meta <= {position_sensor_4, position_sensor_3,
                         position_sensor_2, position_sensor_1};
         sensor_sync <= sensor_meta;
      end
   end

   // ---------------------------------------------------------------
   // restart and switch sampling
   // ---------------------------------------------------------------
   node_state_t state;
   node_state_t next_state;
   logic [1:0] settle;
   logic [1:0] next_settle;
   logic [NODE_W-1:0] next_node_id;
   logic [RATE_W-1:0] next_bit_rate_code;
   logic next_rate_invalid;
   logic next_online;

   always_comb
   begin
      next_state = state;
      next_settle = settle;
      next_node_id = node_id;
      next_bit_rate_code = bit_rate_code;
      next_rate_invalid = rate_invalid;
      next_online = online;
      unique case (state)
         ST_SAMPLE:
         begin
            // wait out the synchroniser so reset zeros are never latched
            if (settle == SETTLE_CYCLES - 2'h1)
            begin
               next_node_id = dip_sync[NODE_LSB +: NODE_W]; // [RL1] [RL2] [RL5]
               next_bit_rate_code = dip_sync[RATE_LSB +: RATE_W]; // [RL3] [RL5]
               next_rate_invalid = (dip_sync[RATE_LSB +: RATE_W] == RATE_BAD); // [RL4]
               next_online = (dip_sync[RATE_LSB +: RATE_W] != RATE_BAD); // [RL4]
               next_state = next_online ? ST_RUN : ST_HALT;
            end
            else
            begin
               next_settle = settle + 2'h1;
            end
         end
         ST_RUN, ST_HALT:
         begin
            if (reset_msg)
            begin
               next_state = ST_SAMPLE; // [RL6]
               next_settle = 2'h0;
               next_online = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state <= ST_SAMPLE; // [RL6]
         settle <= 2'h0;
         node_id <= '0;
         bit_rate_code <= RATE_125K;
         rate_invalid <= 1'b0;
         online <= 1'b0;
      end
      else
      begin
         state <= next_state;
         settle <= next_settle;
         node_id <= next_node_id;
         bit_rate_code <= next_bit_rate_code;
         rate_invalid <= next_rate_invalid;
         online <= next_online;
      end
   end

   // ---------------------------------------------------------------
   // process data, explicit reads and register port
   // ---------------------------------------------------------------
   logic [7:0] layout_in;
   logic [7:0] layout_out;
   logic [2:0] valves;
   logic [7:0] next_layout_in;
   logic [7:0] next_layout_out;
   logic [2:0] next_valves;
   logic [DATA_W-1:0] next_reg_rdata;
   logic next_tx_valid;
   logic [1:0] next_tx_len;
   logic [7:0] next_tx_byte0;
   logic [7:0] next_tx_byte1;
   logic next_conn_accept;
   logic next_conn_reject;
   logic next_expl_ack;
   logic next_expl_ok;
   logic [1:0] next_expl_len;
   logic [7:0] next_expl_byte0;
   logic [7:0] next_expl_byte1;
   logic [18:0] prod;
   logic [18:0] expl;
   logic [7:0] wr_in;
   logic [7:0] wr_out;

   always_comb
   begin
      prod = read_layout(layout_in, sensor_sync, valves);
      expl = read_layout(expl_inst, sensor_sync, valves);
      wr_in = reg_wdata[LAY_IN_LSB +: 8];
      wr_out = reg_wdata[LAY_OUT_LSB +: 8];
      next_layout_in = layout_in;
      next_layout_out = layout_out;
      next_valves = valves;
      next_reg_rdata = '0;
      next_tx_valid = 1'b0;
      next_tx_len = tx_len;
      next_tx_byte0 = tx_byte0;
      next_tx_byte1 = tx_byte1;
      next_conn_accept = 1'b0;
      next_conn_reject = 1'b0;
      next_expl_ack = 1'b0;
      next_expl_ok = expl_ok;
      next_expl_len = expl_len;
      next_expl_byte0 = expl_byte0;
      next_expl_byte1 = expl_byte1;

      // software-selected active layouts; other instances refused
      if (reg_wr && reg_addr == REG_LAYOUT
          && (wr_in == IN1_INST || wr_in == IN2_INST) && wr_out == OUT_INST)
      begin
         next_layout_in = wr_in; // [RL7] [RL8]
         next_layout_out = wr_out;
      end
      if (reg_wr && reg_addr == REG_VALVES)
      begin
         next_valves = reg_wdata[2:0]; // [RL15]
      end

      if (conn_setup && online)
      begin
         if ((conn_prod_inst == IN1_INST || conn_prod_inst == IN2_INST)
             && conn_cons_inst == OUT_INST)
         begin
            next_layout_in = conn_prod_inst; // [RL8]
            next_layout_out = conn_cons_inst;
            next_conn_accept = 1'b1;
         end
         else
         begin
            next_conn_reject = 1'b1;
         end
      end

      if (rx_valid && online)
      begin
         next_valves = rx_byte[2:0]; // [RL11] [RL12] [RL15]
      end

      // halted node never transmits
      if (produce_tick && online)
      begin
         next_tx_valid = 1'b1; // [RL13] [RL4]
         next_tx_len = prod[17:16];
         next_tx_byte0 = prod[15:8];
         next_tx_byte1 = prod[7:0];
      end

      if (expl_req && online)
      begin
         next_expl_ack = 1'b1; // [RL14]
         next_expl_ok = expl[18] && expl_class == ASM_CLASS && expl_attr == ASM_ATTR;
         next_expl_len = next_expl_ok ? expl[17:16] : 2'h0;
         next_expl_byte0 = next_expl_ok ? expl[15:8] : 8'h00;
         next_expl_byte1 = next_expl_ok ? expl[7:0] : 8'h00;
      end

      if (reg_rd)
      begin
         unique case (reg_addr)
            REG_LAYOUT: next_reg_rdata = {16'h0000, layout_out, layout_in};
            REG_STATUS:
            begin
               next_reg_rdata[ST_NODE_LSB +: NODE_W] = node_id;
               next_reg_rdata[ST_RATE_LSB +: RATE_W] = bit_rate_code;
               next_reg_rdata[ST_BAD_BIT] = rate_invalid;
               next_reg_rdata[ST_ONLINE_BIT] = online;
            end
            REG_VALVES: next_reg_rdata = {29'h0, valves};
            REG_INPUTS: next_reg_rdata = {24'h0, prod[15:8]};
            default: next_reg_rdata = '0;
         endcase
      end

      // restart drops the outputs to their safe de-energised state
      if (reset_msg && state != ST_SAMPLE)
      begin
         next_valves = 3'h0; // [RL6]
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         layout_in <= IN1_INST;
         layout_out <= OUT_INST;
         valves <= 3'h0;
         reg_rdata <= '0;
         tx_valid <= 1'b0;
         tx_len <= 2'h0;
         tx_byte0 <= 8'h00;
         tx_byte1 <= 8'h00;
         conn_accept <= 1'b0;
         conn_reject <= 1'b0;
         expl_ack <= 1'b0;
         expl_ok <= 1'b0;
         expl_len <= 2'h0;
         expl_byte0 <= 8'h00;
         expl_byte1 <= 8'h00;
      end
      else
      begin
         layout_in <= next_layout_in;
         layout_out <= next_layout_out;
         valves <= next_valves;
         reg_rdata <= next_reg_rdata;
         tx_valid <= next_tx_valid;
         tx_len <= next_tx_len;
         tx_byte0 <= next_tx_byte0;
         tx_byte1 <= next_tx_byte1;
         conn_accept <= next_conn_accept;
         conn_reject <= next_conn_reject;
         expl_ack <= next_expl_ack;
         expl_ok <= next_expl_ok;
         expl_len <= next_expl_len;
         expl_byte0 <= next_expl_byte0;
         expl_byte1 <= next_expl_byte1;
      end
   end

   assign valve_drive_1 = valves[0];
   assign valve_drive_2 = valves[1];
   assign valve_drive_3 = valves[2];

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   property p_node_id;
      $rose(online) |-> node_id == $past(dip_sync[NODE_LSB +: NODE_W]);
   endproperty
   a_node_id: assert property (p_node_id) else $error("node id not from switches"); // [RL1]

   property p_rate;
      $rose(online) |-> bit_rate_code == $past(dip_sync[RATE_LSB +: RATE_W])
                        && bit_rate_code != RATE_BAD;
   endproperty
   a_rate: assert property (p_rate) else $error("bad rate while online"); // [RL3]

   property p_silent;
      rate_invalid |-> !online && !tx_valid && !expl_ack;
   endproperty
   a_silent: assert property (p_silent) else $error("invalid rate node talks"); // [RL4]

   property p_hold_cfg;
      online && !reset_msg |=> $stable(node_id) && $stable(bit_rate_code);
   endproperty
   a_hold_cfg: assert property (p_hold_cfg) else $error("config changed running"); // [RL5]

   property p_restart;
      online && reset_msg |=> !online ##3 (online || rate_invalid);
   endproperty
   a_restart: assert property (p_restart) else $error("restart sequence wrong"); // [RL6]

   property p_layouts;
      (layout_in == IN1_INST || layout_in == IN2_INST) && layout_out == OUT_INST;
   endproperty
   a_layouts: assert property (p_layouts) else $error("illegal active layout"); // [RL8]

   property p_produce;
      online && produce_tick |=> tx_valid
         && tx_len == (($past(layout_in) == IN2_INST) ? LEN_TWO : LEN_ONE)
         && tx_byte0 == {4'h0, $past(sensor_sync)};
   endproperty
   a_produce: assert property (p_produce) else $error("produced data wrong"); // [RL13]

   property p_unused_in;
      tx_valid |-> tx_byte0[7:4] == 4'h0 && tx_byte1 == 8'h00;
   endproperty
   a_unused_in: assert property (p_unused_in) else $error("unused bits set"); // [RL15]

   property p_consume;
      online && rx_valid && !reset_msg |=> valve_drive_1 == $past(rx_byte[0])
         && valve_drive_2 == $past(rx_byte[1]) && valve_drive_3 == $past(rx_byte[2]);
   endproperty
   a_consume: assert property (p_consume) else $error("valves not driven"); // [RL11]

   // back-to-back requests are legal, so ack must track each request exactly
   property p_explicit;
      expl_ack == $past(online && expl_req);
   endproperty
   a_explicit: assert property (p_explicit) else $error("explicit read unanswered"); // [RL14]

   c_online: cover property ($rose(online));
   c_tx_two: cover property (tx_valid && tx_len == LEN_TWO);
   c_expl_ok: cover property (expl_ack && expl_ok);
   c_bad_rate: cover property (rate_invalid);

endmodule

// ==== testbench/dnet_master_model.sv ====
`timescale 1ns/100ps

// ---------------------------------------------------------------
// scanner side: one request per call, idle cycle after each
// ---------------------------------------------------------------
module dnet_master_model
(
   input wire logic ref_clk, // system clock
   output logic reset_msg, // restart request
   output logic conn_setup, // connection setup
   output logic [7:0] conn_prod_inst, // produced path instance
   output logic [7:0] conn_cons_inst, // consumed path instance
   output logic produce_tick, // cyclic poll
   output logic rx_valid, // output data strobe
   output logic [7:0] rx_byte, // output data byte
   output logic expl_req, // explicit read
   output logic [7:0] expl_class, // class
   output logic [7:0] expl_inst, // instance
   output logic [7:0] expl_attr // attribute
);
   initial
   begin
      {reset_msg, conn_setup, produce_tick, rx_valid, expl_req} = 5'h00;
      {conn_prod_inst, conn_cons_inst, rx_byte} = 24'h000000;
      {expl_class, expl_inst, expl_attr} = 24'h000000;
   end

   // stale fields inverted after use, so nothing leans on old values
   task automatic send_reset();
      @(posedge ref_clk) reset_msg <= 1'b1;
      @(posedge ref_clk) reset_msg <= 1'b0;
   endtask

   task automatic setup(input logic [7:0] p, input logic [7:0] c);
      @(posedge ref_clk);
      conn_setup <= 1'b1;
      conn_prod_inst <= p;
      conn_cons_inst <= c;
      @(posedge ref_clk);
      conn_setup <= 1'b0;
      conn_prod_inst <= ~p;
      conn_cons_inst <= ~c;
   endtask

   task automatic poll();
      @(posedge ref_clk) produce_tick <= 1'b1;
      @(posedge ref_clk) produce_tick <= 1'b0;
   endtask

   task automatic send_out(input logic [7:0] b);
      @(posedge ref_clk);
      rx_valid <= 1'b1;
      rx_byte <= b;
      @(posedge ref_clk);
      rx_valid <= 1'b0;
      rx_byte <= ~b;
   endtask

   task automatic read(input logic [7:0] c, input logic [7:0] i, input logic [7:0] a);
      @(posedge ref_clk);
      expl_req <= 1'b1;
      {expl_class, expl_inst, expl_attr} <= {c, i, a};
      @(posedge ref_clk);
      expl_req <= 1'b0;
      {expl_class, expl_inst, expl_attr} <= ~{c, i, a};
   endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/100ps

module tb;
   import dnet_node_pkg::*;

   typedef struct {logic [7:0] sw; logic [5:0] node; logic [1:0] rate; logic bad;} row_t;

   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] dip_sw = 8'h00;
   logic [3:0] sens = 4'h0;
   logic [ADDR_W-1:0] reg_addr = 8'h00;
   logic [DATA_W-1:0] reg_wdata = 32'h00000000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [5:0] node_id;
   logic [1:0] bit_rate_code, tx_len, expl_len;
   logic rate_invalid, online, v1, v2, v3, tx_valid, conn_accept, conn_reject;
   logic expl_ack, expl_ok, reset_msg, conn_setup, produce_tick, rx_valid, expl_req;
   logic [7:0] tx_byte0, tx_byte1, expl_byte0, expl_byte1, prod_i, cons_i, rx_byte;
   logic [7:0] e_class, e_inst, e_attr;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   row_t rows [4] = '{'{8'h00, 6'h00, 2'h0, 1'b0}, '{8'h7f, 6'h3f, 2'h1, 1'b0},
                      '{8'h95, 6'h15, 2'h2, 1'b0}, '{8'hea, 6'h2a, 2'h3, 1'b1}};

   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end

   dnet_master_model u_dnet_master_model (.ref_clk(ref_clk), .reset_msg(reset_msg),
      .conn_setup(conn_setup), .conn_prod_inst(prod_i), .conn_cons_inst(cons_i),
      .produce_tick(produce_tick), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .expl_req(expl_req), .expl_class(e_class), .expl_inst(e_inst), .expl_attr(e_attr));

   dnet_node_io u_dnet_node_io (.ref_clk(ref_clk), .rst_n(rst_n), .dip_sw(dip_sw),
      .position_sensor_1(sens[0]), .position_sensor_2(sens[1]),
      .position_sensor_3(sens[2]), .position_sensor_4(sens[3]), .reset_msg(reset_msg),
      .conn_setup(conn_setup), .conn_prod_inst(prod_i), .conn_cons_inst(cons_i),
      .produce_tick(produce_tick), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .expl_req(expl_req), .expl_class(e_class), .expl_inst(e_inst), .expl_attr(e_attr),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .node_id(node_id), .bit_rate_code(bit_rate_code),
      .rate_invalid(rate_invalid), .online(online), .valve_drive_1(v1),
      .valve_drive_2(v2), .valve_drive_3(v3), .tx_valid(tx_valid), .tx_len(tx_len),
      .tx_byte0(tx_byte0), .tx_byte1(tx_byte1), .conn_accept(conn_accept),
      .conn_reject(conn_reject), .expl_ack(expl_ack), .expl_ok(expl_ok),
      .expl_len(expl_len), .expl_byte0(expl_byte0), .expl_byte1(expl_byte1));

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // bounded wait for the node to settle after a restart
   task automatic wait_up();
      int n;
      n = 0;
      while (online !== 1'b1 && rate_invalid !== 1'b1 && n < 10)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
   endtask

   task automatic do_reset(input logic [7:0] sw);
      @(posedge ref_clk);
      dip_sw <= sw;
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_up();
   endtask

   task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      if (wr)
         reg_wr <= 1'b1;
      else
         reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
   endtask

   task automatic expl(input logic [7:0] i, input logic [7:0] c, input logic [19:0] exp);
      u_dnet_master_model.read(c, i, ASM_ATTR);
      #1;
      check({expl_ack, expl_ok, expl_len, expl_byte0, expl_byte1}, exp);
   endtask

   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         final_report();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      foreach (rows[k])
      begin
         do_reset(rows[k].sw);
         check({node_id, bit_rate_code, rate_invalid, online},
               {rows[k].node, rows[k].rate, rows[k].bad, ~rows[k].bad});
         u_dnet_master_model.poll();
         #1;
         check(tx_valid, !rows[k].bad);
      end
      // switches moved while running take effect only on restart
      do_reset(8'h05);
      dip_sw <= 8'h0a;
      repeat (5) @(posedge ref_clk);
      #1;
      check(node_id, 6'h05);
      u_dnet_master_model.send_out(8'hfd);
      #1;
      check({v3, v2, v1}, 3'h5);
      expl(OUT_INST, ASM_CLASS, {4'hd, 8'h05, 8'h00});
      u_dnet_master_model.send_reset();
      repeat (2) @(posedge ref_clk);
      #1;
      check({online, v3, v2, v1}, 4'h0);
      wait_up();
      check(node_id, 6'h0a);
      // process data through both input layouts
      sens <= 4'ha;
      repeat (4) @(posedge ref_clk);
      u_dnet_master_model.poll();
      #1;
      check({tx_valid, tx_len, tx_byte0, tx_byte1}, {3'h5, 8'h0a, 8'h00});
      expl(IN1_INST, ASM_CLASS, {4'hd, 8'h0a, 8'h00});
      expl(IN2_INST, ASM_CLASS, {4'he, 8'h0a, 8'h00});
      expl(IN2_INST, 8'h05, 20'h80000);
      u_dnet_master_model.setup(IN2_INST, OUT_INST);
      #1;
      check({conn_accept, conn_reject}, 2'h2);
      u_dnet_master_model.poll();
      #1;
      check({tx_valid, tx_len, tx_byte0, tx_byte1}, {3'h6, 8'h0a, 8'h00});
      u_dnet_master_model.setup(8'h03, OUT_INST);
      #1;
      check({conn_accept, conn_reject}, 2'h1);
      // register port
      reg_access(1'b0, REG_LAYOUT, 32'h0);
      check(reg_rdata, 32'h00001502);
      reg_access(1'b1, REG_LAYOUT, 32'h00001503);
      reg_access(1'b1, REG_LAYOUT, 32'h00001501);
      reg_access(1'b0, REG_LAYOUT, 32'h0);
      check(reg_rdata, 32'h00001501);
      reg_access(1'b0, REG_STATUS, 32'h0);
      check(reg_rdata, 32'h0000200a);
      reg_access(1'b1, REG_VALVES, 32'hffffff03);
      check({v3, v2, v1}, 3'h3);
      reg_access(1'b0, REG_INPUTS, 32'h0);
      check(reg_rdata, 32'h0000000a);
      reg_access(1'b0, 8'h10, 32'h0);
      check(reg_rdata, 32'h00000000);
      final_report();
   end
endmodule
